// File: design/mhc_pkg.sv
// mhc_pkg: register map, field layout and shared helpers for the mic filter
// and level compressor; assumes 16-bit signed audio samples.
package mhc_pkg;
	localparam int unsigned SAMPLE_W = 16;
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_MIC_FILTER = 8'h26;
	localparam logic [7:0] IDX_LEVEL_CTL = 8'h28;
	localparam logic [7:0] IDX_SLOPES = 8'h2A;
	localparam logic [7:0] IDX_KNEE = 8'h2B;
	localparam logic [7:0] IDX_STATUS = 8'h2C;
	// field positions
	localparam int unsigned HPF_EN_BIT = 4;
	localparam int unsigned HPF_CUT_LSB = 5;
	localparam int unsigned COMP_EN_BIT = 15;
	localparam int unsigned COMP_PATH_BIT = 14;
	localparam int unsigned UP_LSB = 3;
	localparam int unsigned LO_LSB = 0;
	localparam int unsigned KIP_LSB = 5;
	localparam int unsigned KOP_LSB = 0;
	// reset values and writable bits
	localparam logic [15:0] MIC_FILTER_RST = 16'h0010;
	localparam logic [15:0] LEVEL_CTL_RST = 16'h0000;
	localparam logic [15:0] SLOPES_RST = 16'h0000;
	localparam logic [15:0] KNEE_RST = 16'h0000;
	localparam logic [15:0] MIC_FILTER_MASK = 16'h0070;
	localparam logic [15:0] LEVEL_CTL_MASK = 16'hC000;
	localparam logic [15:0] SLOPES_MASK = 16'h003F;
	localparam logic [15:0] KNEE_MASK = 16'h07FF;
	// highest legal codes; the top slope code means slope 0
	localparam logic [5:0] KIP_MAX = 6'h3C;
	localparam logic [4:0] KOP_MAX = 5'h1E;
	localparam logic [2:0] UP_MAX = 3'h5;
	localparam logic [2:0] LO_MAX = 3'h4;
	// one-pole shift per cut-off mode, cut-off tracks the sample rate
	localparam logic [3:0] HPF_SHIFT_HIFI = 4'hB;
	localparam logic [3:0] HPF_SHIFT_V1 = 4'h4;
	localparam logic [3:0] HPF_SHIFT_V2 = 4'h3;
	localparam logic [3:0] HPF_SHIFT_V3 = 4'h2;
	localparam int unsigned HPF_FRAC = 8;
	// level estimate, 0.75 dB steps below full scale
	localparam logic [7:0] LEVEL_FS = 8'h78;
	localparam logic [7:0] LEVEL_SILENT = 8'h7F;
	// 2^(k/8) in Q1.14
	localparam logic [15:0] GAIN_FRAC [8] = '{16'h4000, 16'h45CB, 16'h4C1C, 16'h52FF,
		16'h5A82, 16'h62B4, 16'h6BA2, 16'h7560};
	localparam int unsigned GAIN_Q = 14;
	localparam int unsigned GAIN_BIAS = 16;

	typedef enum logic [1:0] {
		CUT_HIFI = 2'h0,
		CUT_VOICE1 = 2'h1,
		CUT_VOICE2 = 2'h2,
		CUT_VOICE3 = 2'h3
	} mhc_cut_type;

	// slope code to {slope is zero, right shift}, reserved codes clamp
	function automatic logic [3:0] mhc_slope_decode(input logic [2:0] code,
		input logic [2:0] max_code);
		logic [2:0] c;
		c = (code > max_code) ? max_code : code;
		mhc_slope_decode = (c == max_code) ? 4'h8 : {1'b0, c};
	endfunction : mhc_slope_decode

	// clamp a wide signed value into one sample
	function automatic logic [15:0] mhc_sat16(input logic signed [63:0] v);
		if (v > 64'sh7FFF) begin
			mhc_sat16 = 16'h7FFF;
		end else if (v < -64'sh8000) begin
			mhc_sat16 = 16'h8000;
		end else begin
			mhc_sat16 = v[15:0];
		end
	endfunction : mhc_sat16
endpackage : mhc_pkg

// File: design/mhc_stream_if.sv
// mhc_stream_if: one sample stream, valid with data, no back-pressure.
// assumes the source holds valid for exactly one cycle per sample.
`timescale 1ns/1ps
interface mhc_stream_if;
	logic valid;
	logic signed [15:0] data;
	modport src (output valid, output data);
	modport snk (input valid, input data);
endinterface : mhc_stream_if

// File: design/mhc_highpass.sv
// mhc_highpass: first-order dc-blocking high-pass on the mic stream.
// assumes one sample per valid pulse; one cycle latency.
`timescale 1ns/1ps
module mhc_highpass
	import mhc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic [1:0] cutoff_i,
	mhc_stream_if.snk in_s,
	mhc_stream_if.src out_s
);
	typedef struct packed {
		logic signed [15:0] x1;
		logic signed [31:0] acc;
		logic valid;
		logic signed [15:0] data;
	} mhc_hpf_state_type;

	mhc_hpf_state_type st_ff;
	mhc_hpf_state_type st_nxt;
	logic [3:0] shift;
	logic signed [31:0] diff;

	// cut-off mode picks the pole; per-sample update keeps fc proportional to fs
	always_comb begin
		unique case (mhc_cut_type'(cutoff_i))
			CUT_HIFI: shift = HPF_SHIFT_HIFI;
			CUT_VOICE1: shift = HPF_SHIFT_V1;
			CUT_VOICE2: shift = HPF_SHIFT_V2;
			CUT_VOICE3: shift = HPF_SHIFT_V3;
		endcase
		st_nxt = st_ff;
		diff = 32'(in_s.data) - 32'(st_ff.x1);
		st_nxt.valid = in_s.valid;
		if (in_s.valid) begin
			st_nxt.x1 = in_s.data;
			if (enable_i) begin
				st_nxt.acc = st_ff.acc + (diff <<< HPF_FRAC) - (st_ff.acc >>> shift);
				st_nxt.data = mhc_sat16(64'(st_nxt.acc >>> HPF_FRAC));
			end else begin
				st_nxt.acc = 32'sh0; // filter state dropped while bypassed
				st_nxt.data = in_s.data;
			end
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= st_nxt;
		end
	end

	assign out_s.valid = st_ff.valid;
	assign out_s.data = st_ff.data;
endmodule : mhc_highpass

// File: design/mhc_level_est.sv
// mhc_level_est: log-domain level of one sample, 0.75 dB per step below
// full scale; combinational, assumes 16-bit signed input.
`timescale 1ns/1ps
module mhc_level_est
	import mhc_pkg::*;
(
	input wire logic signed [15:0] sample_i,
	output logic [7:0] level_o
);
	logic [15:0] mag;
	logic [15:0] norm;
	logic [3:0] msb;
	logic [7:0] up;

	// one octave is eight steps, three bits below the leading one refine it
	always_comb begin
		mag = sample_i[15] ? 16'(-sample_i) : 16'(sample_i);
		msb = 4'h0;
		for (int i = 0; i < SAMPLE_W; i++) begin
			if (mag[i]) begin
				msb = 4'(i);
			end
		end
		norm = mag << (4'hF - msb);
		up = {1'b0, msb, norm[14:12]};
		if (mag == 16'h0000) begin
			level_o = LEVEL_SILENT;
		end else if (up >= LEVEL_FS) begin
			level_o = 8'h00;
		end else begin
			level_o = LEVEL_FS - up;
		end
	end
endmodule : mhc_level_est

// File: design/mhc_top.sv
// mhc_top: mic high-pass filter and static-curve level compressor with a
// classic wishbone register slave; samples arrive as valid pulses.
// assumes one clock for bus and samples and a synchronous reset.
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
module mhc_top
	import mhc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic mic_valid_i,
	input wire logic signed [15:0] mic_data_i,
	output logic mic_valid_o,
	output logic signed [15:0] mic_data_o,
	input wire logic play_valid_i,
	input wire logic signed [15:0] play_data_i,
	output logic play_valid_o,
	output logic signed [15:0] play_data_o
);
	// every flip-flop of mhc_top outside the high-pass stage lives in one record:
	// control registers, bus answer, both output stages
	// and the registered full-scale level
	typedef struct packed {
		logic [15:0] mic_filter;
		logic [15:0] level_ctl;
		logic [15:0] slopes;
		logic [15:0] knee;
		logic ack;
		logic [31:0] rdata;
		logic mic_v;
		logic signed [15:0] mic_d;
		logic play_v;
		logic signed [15:0] play_d;
		logic signed [7:0] fullscale_output_level;
	} mhc_top_state_type;

	mhc_top_state_type st_ff;
	mhc_top_state_type st_nxt;

	// streams into and out of the high-pass stage
	mhc_stream_if hpf_in_s ();
	mhc_stream_if hpf_out_s ();

	// sel[3:2] and the upper data half are ignored, registers are 16 bits
	// byte-lane merge of a 16-bit register, unwritable bits forced to zero
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] dat, input logic [3:0] sel, input logic [15:0] mask);
		logic [15:0] v;
		v = old;
		if (sel[0]) begin
			v[7:0] = dat[7:0];
		end
		if (sel[1]) begin
			v[15:8] = dat[15:8];
		end
		merge16 = v & mask;
	endfunction : merge16

	// decoded control fields
	logic hpf_en;
	logic [1:0] hpf_cut;
	logic comp_en;
	logic comp_path;
	logic [5:0] kip;
	logic [4:0] kop;
	logic [3:0] up_dec;
	logic [3:0] lo_dec;

	assign hpf_en = st_ff.mic_filter[HPF_EN_BIT];
	assign hpf_cut = st_ff.mic_filter[HPF_CUT_LSB +: 2];
	assign comp_en = st_ff.level_ctl[COMP_EN_BIT];
	assign comp_path = st_ff.level_ctl[COMP_PATH_BIT];

	// reserved codes read back as written; only the datapath clamps them
	// reserved codes fall back to the nearest legal setting
	always_comb begin
		kip = st_ff.knee[KIP_LSB +: 6];
		if (kip > KIP_MAX) begin
			kip = KIP_MAX;
		end
		kop = st_ff.knee[KOP_LSB +: 5];
		if (kop > KOP_MAX) begin
			kop = KOP_MAX;
		end
		up_dec = mhc_slope_decode(st_ff.slopes[UP_LSB +: 3], UP_MAX);
		lo_dec = mhc_slope_decode(st_ff.slopes[LO_LSB +: 3], LO_MAX);
	end

	// mic samples pass the high-pass first
	assign hpf_in_s.valid = mic_valid_i;
	assign hpf_in_s.data = mic_data_i;

	mhc_highpass mhc_highpass_i (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.enable_i(hpf_en),
		.cutoff_i(hpf_cut),
		.in_s(hpf_in_s),
		.out_s(hpf_out_s)
	);

	// a path change while a mic sample sits in the filter stage only
	// changes which gain that sample gets; both output stages always
	// follow their own input streams, so no sample is lost or swapped
	// the compressor sees exactly one of the two streams
	logic sel_v;
	logic signed [15:0] sel_d;
	logic oth_v;
	logic signed [15:0] oth_d;

	// selected stream feeds the curve, the other is only re-timed
	always_comb begin
		if (comp_path) begin
			sel_v = play_valid_i;
			sel_d = play_data_i;
			oth_v = hpf_out_s.valid;
			oth_d = hpf_out_s.data;
		end else begin
			sel_v = hpf_out_s.valid;
			sel_d = hpf_out_s.data;
			oth_v = play_valid_i;
			oth_d = play_data_i;
		end
	end

	// instantaneous level of the selected sample
	logic [7:0] level;

	// the level comes from the very sample that takes the gain, so the
	// curve is static: no averaging, attack or decay
	mhc_level_est mhc_level_est_i (
		.sample_i(sel_d),
		.level_o(level)
	);

	// all levels below are attenuation steps of 0.75 dB below full scale;
	// a larger number means a quieter signal
	// above the knee d_s <= 0 and the upper slope applies, below it the lower
	// a slope code is a right shift, the top code of each field is slope 0
	// static curve in attenuation steps: o = kop + (a - kip) * slope
	logic [7:0] kip_sc;
	logic signed [9:0] a_s;
	logic signed [9:0] d_s;
	logic [9:0] dmag;
	logic signed [9:0] o_s;
	logic signed [9:0] g_s;
	logic signed [9:0] gi_s;
	logic [4:0] gshift;
	logic signed [63:0] prod;
	logic signed [63:0] scaled;
	logic signed [15:0] comp_d;
	logic signed [7:0] fullscale_output_level;

	always_comb begin
		// full-scale output level: knee output less the scaled knee input
		kip_sc = up_dec[3] ? 8'h00 : ({2'b00, kip} >> up_dec[2:0]);
		fullscale_output_level = 8'({3'b000, kop}) - 8'(kip_sc);
		// distance of the input from the knee
		a_s = 10'({2'b00, level});
		d_s = a_s - 10'({4'h0, kip});
		if (d_s <= 10'sh0) begin
			dmag = 10'(-d_s);
			if (up_dec[3]) begin
				o_s = 10'({5'h00, kop});
			end else begin
				o_s = 10'({5'h00, kop}) - 10'(dmag >> up_dec[2:0]);
			end
		end else begin
			dmag = 10'(d_s);
			if (lo_dec[3]) begin
				o_s = 10'({5'h00, kop});
			end else begin
				o_s = 10'({5'h00, kop}) + 10'(dmag >> lo_dec[2:0]);
			end
		end

		// the gain shift reaches 31 only for silence or a flat lower slope
		// with knee output 0; the shifted product still fits 64 bits
		// positive gain means boost; split into octaves and eighths
		g_s = a_s - o_s;
		gi_s = g_s >>> 3;
		if (gi_s < -10'sd16) begin
			gshift = 5'h00;
		end else begin
			gshift = 5'(gi_s + 10'sd16);
		end
		prod = 64'(sel_d) * 64'(signed'({1'b0, GAIN_FRAC[g_s[2:0]]}));
		scaled = (prod <<< gshift) >>> (GAIN_Q + GAIN_BIAS);
		comp_d = comp_en ? mhc_sat16(scaled) : sel_d;
	end

	// every access is answered one cycle after it is taken; the ack flop
	// itself blocks a second take in the cycle where ack stands
	// register access decode
	logic bus_req;
	logic [7:0] bus_idx;
	logic [15:0] status;

	assign bus_req = wb_cyc_i && wb_stb_i && !st_ff.ack;
	assign bus_idx = wb_adr_i[9:2];
	assign status = {6'h00, comp_path, comp_en, st_ff.fullscale_output_level};

	// writes commit at the taking edge, so the next read returns the new
	// value; the full-scale level in status follows one cycle later
	// next state: registers, bus answer and both sample outputs
	always_comb begin
		st_nxt = st_ff;
		st_nxt.ack = bus_req;
		st_nxt.fullscale_output_level = fullscale_output_level;
		// register writes, byte lanes merged and masked
		if (bus_req && wb_we_i) begin
			unique case (bus_idx)
				IDX_MIC_FILTER: begin
					st_nxt.mic_filter = merge16(st_ff.mic_filter, wb_dat_i, wb_sel_i,
						MIC_FILTER_MASK);
				end
				IDX_LEVEL_CTL: begin
					st_nxt.level_ctl = merge16(st_ff.level_ctl, wb_dat_i, wb_sel_i,
						LEVEL_CTL_MASK);
				end
				IDX_SLOPES: begin
					st_nxt.slopes = merge16(st_ff.slopes, wb_dat_i, wb_sel_i, SLOPES_MASK);
				end
				IDX_KNEE: begin
					st_nxt.knee = merge16(st_ff.knee, wb_dat_i, wb_sel_i, KNEE_MASK);
				end
				default: begin
				end
			endcase
		end

		// read data for the answer cycle; unmapped indices read zero
		if (bus_req) begin
			unique case (bus_idx)
				IDX_MIC_FILTER: st_nxt.rdata = {16'h0000, st_ff.mic_filter};
				IDX_LEVEL_CTL: st_nxt.rdata = {16'h0000, st_ff.level_ctl};
				IDX_SLOPES: st_nxt.rdata = {16'h0000, st_ff.slopes};
				IDX_KNEE: st_nxt.rdata = {16'h0000, st_ff.knee};
				IDX_STATUS: st_nxt.rdata = {16'h0000, status};
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end

		// the selected stream takes the gain, the other passes as it came
		if (comp_path) begin
			st_nxt.play_v = sel_v;
			st_nxt.play_d = sel_v ? comp_d : st_ff.play_d;
			st_nxt.mic_v = oth_v;
			st_nxt.mic_d = oth_v ? oth_d : st_ff.mic_d;
		end else begin
			st_nxt.mic_v = sel_v;
			st_nxt.mic_d = sel_v ? comp_d : st_ff.mic_d;
			st_nxt.play_v = oth_v;
			st_nxt.play_d = oth_v ? oth_d : st_ff.play_d;
		end
	end

	// synchronous reset: control registers to their power-on values,
	// everything else to zero
	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
			st_ff.mic_filter <= MIC_FILTER_RST;
			st_ff.level_ctl <= LEVEL_CTL_RST;
			st_ff.slopes <= SLOPES_RST;
			st_ff.knee <= KNEE_RST;
		end else begin
			st_ff <= st_nxt;
		end
	end

	// all outputs come straight from the state record
	assign wb_ack_o = st_ff.ack;
	assign wb_dat_o = st_ff.rdata;
	assign mic_valid_o = st_ff.mic_v;
	assign mic_data_o = st_ff.mic_d;
	assign play_valid_o = st_ff.play_v;
	assign play_data_o = st_ff.play_d;
endmodule : mhc_top

// File: tb/mhc_sample_src.sv
// mhc_sample_src: audio stage feeding one sample stream of the block.
// assumes send_i is driven right after a rising edge for one cycle per sample.
`timescale 1ns/1ps
module mhc_sample_src (
	input wire logic clk_i,
	input wire logic send_i,
	input wire logic [15:0] val_i,
	output logic valid_o,
	output logic signed [15:0] data_o
);
	initial begin
		valid_o = 1'b0;
		data_o = 16'h5A5A;
	end
	// one-cycle strobe; between samples the data toggles so stale data matches the sample only every second cycle
	always @(posedge clk_i) begin
		valid_o <= send_i;
		data_o <= send_i ? val_i : ~data_o;
	end
endmodule : mhc_sample_src

// File: tb/mhc_top_assertions.sv
// mhc_top_assertions: port-level checker for the mic filter and compressor.
// assumes it is bound to mhc_top and sees only that module's ports.
`timescale 1ns/1ps
module mhc_top_checker
	import mhc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic mic_valid_i,
	input wire logic signed [15:0] mic_data_i,
	input wire logic mic_valid_o,
	input wire logic signed [15:0] mic_data_o,
	input wire logic play_valid_i,
	input wire logic signed [15:0] play_data_i,
	input wire logic play_valid_o,
	input wire logic signed [15:0] play_data_o
);
	logic comp_en_ff, path_ff, hpf_ff;
	logic take;
	// a write is taken where the request is up and ack is still low
	assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	// shadow copies of the enable and path bits as software wrote them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			comp_en_ff <= 1'b0;
			path_ff <= 1'b0;
			hpf_ff <= 1'b1;
		end else if (take && wb_adr_i[9:2] == IDX_LEVEL_CTL && wb_sel_i[1]) begin
			comp_en_ff <= wb_dat_i[COMP_EN_BIT];
			path_ff <= wb_dat_i[COMP_PATH_BIT];
		end else if (take && wb_adr_i[9:2] == IDX_MIC_FILTER && wb_sel_i[0]) begin
			hpf_ff <= wb_dat_i[HPF_EN_BIT];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_ack_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
	property p_ack; s_take |=> s_ack_pulse; endproperty
	property p_ack_src; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	property p_dat_hi; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
	property p_mic_lat; mic_valid_i |-> ##2 mic_valid_o; endproperty
	property p_mic_src; mic_valid_o |-> $past(mic_valid_i, 2); endproperty
	property p_play_lat; play_valid_i |=> play_valid_o; endproperty
	property p_play_pass;
		play_valid_i && !(comp_en_ff && path_ff) |=> play_data_o == $past(play_data_i);
	endproperty
	property p_mic_pass;
		mic_valid_i && !hpf_ff && !(comp_en_ff && !path_ff)
			|-> ##2 mic_data_o == $past(mic_data_i, 2);
	endproperty
	property p_rst;
		disable iff (1'b0) rst_i |=> !wb_ack_o && !mic_valid_o && !play_valid_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
	a_ack_src: assert property (p_ack_src) else $error("ack without request");
	a_dat_hi: assert property (p_dat_hi) else $error("read data upper half not zero");
	a_mic_lat: assert property (p_mic_lat) else $error("mic sample lost");
	a_mic_src: assert property (p_mic_src) else $error("mic strobe without input");
	a_play_lat: assert property (p_play_lat) else $error("play sample lost");
	a_play_pass: assert property (p_play_pass) else $error("play data altered");
	a_mic_pass: assert property (p_mic_pass) else $error("mic data altered");
	a_rst: assert property (p_rst) else $error("outputs active in reset");
endmodule : mhc_top_checker

bind mhc_top mhc_top_checker mhc_top_checker_i (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.mic_valid_i(mic_valid_i), .mic_data_i(mic_data_i), .mic_valid_o(mic_valid_o),
	.mic_data_o(mic_data_o), .play_valid_i(play_valid_i), .play_data_i(play_data_i),
	.play_valid_o(play_valid_o), .play_data_o(play_data_o));

// File: tb/mhc_top_test.sv
// mhc_top_test: register and sample tests of the mic filter and compressor.
// assumes mhc_top with its wishbone slave and two sample stream sources.
`timescale 1ns/1ps
module mhc_top_test;
	import mhc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, mic_go = 1'b0, play_go = 1'b0;
	logic [9:0] wb_adr = 10'h000;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0000_0000;
	logic [15:0] src_val = 16'h0000;
	logic [31:0] wb_dat_o, q;
	logic wb_ack_o, mic_v, play_v, mic_valid_o, play_valid_o;
	logic signed [15:0] mic_d, play_d, mic_data_o, play_data_o, r;
	logic [7:0] exp8;
	int err_total = 0, n_checks = 0, cyc_cnt = 0;
	logic [9:0] adr_t [5] = '{10'h098, 10'h0A0, 10'h0A8, 10'h0AC, 10'h0FC};
	logic [15:0] rst_t [5] = '{16'h0010, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	logic [15:0] msk_t [5] = '{16'h0070, 16'hC000, 16'h003F, 16'h07FF, 16'h0000};
	logic signed [15:0] lo_t [4] = '{16'sh3F00, 16'sh3000, 16'sh2600, 16'sh1600};
	logic signed [15:0] hi_t [4] = '{16'sh4080, 16'sh3900, 16'sh2F00, 16'sh2000};

	always #5 clk_i = ~clk_i;

	mhc_sample_src mic_src_i (.clk_i(clk_i), .send_i(mic_go), .val_i(src_val),
		.valid_o(mic_v), .data_o(mic_d));
	mhc_sample_src play_src_i (.clk_i(clk_i), .send_i(play_go), .val_i(src_val),
		.valid_o(play_v), .data_o(play_d));
	mhc_top mhc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mic_valid_i(mic_v), .mic_data_i(mic_d),
		.mic_valid_o(mic_valid_o), .mic_data_o(mic_data_o), .play_valid_i(play_v),
		.play_data_i(play_d), .play_valid_o(play_valid_o), .play_data_o(play_data_o));

	// verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	// cycle ceiling against hangs
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_total++;
			report_and_stop();
		end
	end

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// one classic wishbone cycle, held until ack is sampled high
	task automatic wb(input logic we, input logic [9:0] adr, input logic [15:0] d);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= 4'h3;
		wb_dat <= {16'h0000, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	// one sample through the mic or play stream, output caught at its strobe
	task automatic put(input logic pl, input logic [15:0] v);
		int n;
		n = 0;
		src_val <= v;
		if (pl) play_go <= 1'b1;
		else mic_go <= 1'b1;
		@(posedge clk_i);
		mic_go <= 1'b0;
		play_go <= 1'b0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((pl ? play_valid_o : mic_valid_o) !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			$display("[FAIL] sample_strobe expected 1 seen 0");
		end
		r = pl ? play_data_o : mic_data_o;
	endtask : put

	task automatic rng(input string nm, input logic signed [15:0] lo, hi);
		check(nm, {15'h0000, (r >= lo && r <= hi)}, 16'h0001);
	endtask : rng

	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// reset values, then writable bits of the four control registers and an unmapped one; status is not covered
		for (int i = 0; i < 5; i++) begin
			wb(1'b0, adr_t[i], 16'h0000);
			check("reset_value", q[15:0], rst_t[i]);
			wb(1'b1, adr_t[i], 16'hFFFF);
			wb(1'b0, adr_t[i], 16'h0000);
			check("write_mask", q[15:0], msk_t[i]);
		end
		$display("registers done");
		// full-scale level for every upper slope code and one reserved code
		wb(1'b1, 10'h0AC, {5'h00, 6'h30, 5'h1E});
		for (int c = 0; c < 7; c++) begin
			wb(1'b1, 10'h0A8, {10'h000, c[2:0], 3'h0});
			wb(1'b0, 10'h0B0, 16'h0000);
			exp8 = (c >= 5) ? 8'h1E : 8'h1E - (8'h30 >> c);
			check("fullscale_level", q[15:0], {8'h03, exp8});
		end
		$display("fullscale done");
		// play path compressed: flat curve, then knee between two slopes
		wb(1'b1, 10'h0A8, 16'h002C);
		wb(1'b1, 10'h0AC, 16'h001E);
		put(1'b1, 16'h7FFF);
		rng("flat_loud", 16'sh0600, 16'sh0E00);
		put(1'b1, 16'h0100);
		rng("flat_quiet", 16'sh0600, 16'sh0E00);
		wb(1'b1, 10'h0A8, 16'h0028);
		wb(1'b1, 10'h0AC, {5'h00, 6'h10, 5'h10});
		put(1'b1, 16'h0400);
		rng("below_knee", 16'sh03A0, 16'sh0460);
		put(1'b1, 16'h7FFF);
		rng("above_knee", 16'sh1C00, 16'sh2400);
		// mic untouched while compressor sits on play, then play while on mic
		wb(1'b1, 10'h098, 16'h0000);
		put(1'b0, 16'h1234);
		check("mic_bypass", r, 16'h1234);
		wb(1'b1, 10'h0A0, 16'h8000);
		put(1'b1, 16'h8123);
		check("play_unselected", r, 16'h8123);
		wb(1'b1, 10'h0A0, 16'h0000);
		put(1'b0, 16'h8001);
		check("mic_comp_off", r, 16'h8001);
		$display("paths done");
		// step response per cut-off mode from a settled zero state
		for (int m = 0; m < 4; m++) begin
			wb(1'b1, 10'h098, 16'h0000);
			put(1'b0, 16'h0000);
			check("hpf_flush", r, 16'h0000);
			wb(1'b1, 10'h098, {9'h000, m[1:0], 5'h10});
			repeat (4) put(1'b0, 16'h4000);
			rng("hpf_step", lo_t[m], hi_t[m]);
		end
		$display("filter done");
		report_and_stop();
	end
endmodule : mhc_top_test
